// ---- pkg/key_mode_pkg.sv ----
// Constants shared by the terminal key-mode handler.
// Assumes a single 100 MHz clock and a classic Wishbone register bus.
`default_nettype none
package key_mode_pkg;
  // Key event codes presented on the key port
  localparam logic [3:0] KEY_CHAR = 4'h0;
  localparam logic [3:0] KEY_UP = 4'h1;
  localparam logic [3:0] KEY_DOWN = 4'h2;
  localparam logic [3:0] KEY_LEFT = 4'h3;
  localparam logic [3:0] KEY_RIGHT = 4'h4;
  localparam logic [3:0] KEY_RETURN = 4'h5;
  localparam logic [3:0] KEY_ENTER = 4'h6;
  localparam logic [3:0] KEY_DELETE = 4'h7;
  localparam logic [3:0] KEY_SETUP = 4'h8;
  localparam logic [3:0] KEY_POINT = 4'h9;
  localparam logic [3:0] KEY_RESET = 4'hA;
  localparam logic [3:0] KEY_HOLD = 4'hB;
  localparam logic [3:0] KEY_ESC = 4'hC;
  localparam logic [3:0] KEY_SPACE = 4'hD;
  localparam logic [3:0] KEY_EXIT = 4'hE;
  // Character codes sent to the host
  localparam logic [7:0] CODE_CR = 8'h0D;
  localparam logic [7:0] CODE_ESC = 8'h1B;
  localparam logic [7:0] CODE_CTRL_MASK = 8'h1F;
  localparam logic [7:0] CODE_SPACE = 8'h20;
  localparam logic [7:0] CODE_DIGIT0 = 8'h30;
  // Marker bytes for position words in the transmit stream
  localparam logic [7:0] CODE_POS_X = 8'hF1;
  localparam logic [7:0] CODE_POS_Y = 8'hF2;
  // Cursor step sizes
  localparam logic [9:0] STEP_FINE = 10'h001;
  localparam logic [9:0] STEP_COARSE = 10'h00A;
  // Register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PARAM = 4'h8;
  localparam logic [3:0] REG_CURSOR = 4'hC;
  // Control register fields
  localparam int CTRL_ONLINE = 0;
  localparam int CTRL_FLOW = 1;
  localparam int CTRL_INTERP = 2;
  localparam int CTRL_LOC_REQ = 3;
  localparam int CTRL_TEST_EN = 4;
  localparam int CTRL_TEST_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Configuration table shape
  localparam int PARAM_COUNT = 8;
  localparam logic [3:0] PARAM_MAX_RESET = 4'h7;
  // Handler states
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_MENU = 2'b01,
    MODE_LOCATOR = 2'b10
  } mode_type;
endpackage
`default_nettype wire

// ---- rtl/key_mode_handler.sv ----
// Key-event handler: configuration menu, locator cursor, front indicators.
// Assumes synchronised one-cycle key events and a classic Wishbone master.
`default_nettype none
module key_mode_handler #(
  parameter int QUEUE_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  // Key event port
  input wire logic key_valid,
  input wire logic [3:0] key_kind,
  input wire logic [7:0] key_char,
  input wire logic key_shift,
  input wire logic key_ctrl,
  // Printer status
  input wire logic copy_busy,
  // Host byte output
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic host_halt,
  output logic echo_valid,
  output logic [7:0] echo_data,
  output logic bell,
  output logic full_reset,
  output logic cursor_show,
  output logic lamp_online,
  output logic lamp_local,
  output logic lamp_hold,
  output logic lamp_interp,
  output logic lamp_copy,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int QW = $clog2(QUEUE_DEPTH);

  key_mode_pkg::mode_type mode_reg;
  logic [31:0] ctrl_reg;
  logic [2:0] param_reg;
  logic [3:0] setting_reg [key_mode_pkg::PARAM_COUNT];
  logic [3:0] pmax [key_mode_pkg::PARAM_COUNT];
  logic [9:0] cur_x_reg, cur_y_reg;
  logic host_entry_reg;
  logic hold_reg;
  logic [7:0] first_char_reg;
  logic first_pend_reg;
  logic [7:0] queue [QUEUE_DEPTH];
  logic [QW:0] wr_ptr_reg, rd_ptr_reg;
  logic loc_req_d_reg;

  // Byte enqueue request from the key logic, up to four bytes per event
  logic [7:0] push_byte [4];
  logic [2:0] push_count;
  logic [QW:0] used;
  logic room;
  logic key_take;
  logic [9:0] step;
  logic wb_hit;
  logic [3:0] code_hit;
  logic [7:0] exit_code;

  // Decodes a two-letter code into a parameter index; bit 3 flags a miss
  function automatic logic [3:0] code_lookup(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] c;
    c = {a, b};
    unique case (c)
      16'h5453: code_lookup = 4'h0;
      16'h5253: code_lookup = 4'h1;
      16'h4C4C: code_lookup = 4'h2;
      16'h4241: code_lookup = 4'h3;
      16'h5045: code_lookup = 4'h4;
      16'h584F: code_lookup = 4'h5;
      16'h4E4C: code_lookup = 4'h6;
      16'h4B43: code_lookup = 4'h7;
      default: code_lookup = 4'h8;
    endcase
  endfunction

  // Highest legal setting of each parameter
  assign pmax[0] = key_mode_pkg::PARAM_MAX_RESET;
  assign pmax[1] = key_mode_pkg::PARAM_MAX_RESET;
  assign pmax[2] = 4'h1;
  assign pmax[3] = 4'h2;
  assign pmax[4] = 4'h1;
  assign pmax[5] = 4'h1;
  assign pmax[6] = 4'h1;
  assign pmax[7] = 4'h1;

  assign used = wr_ptr_reg - rd_ptr_reg;
  // Four slots must be free so a whole report lands at once
  assign room = (used <= (QW + 1)'(QUEUE_DEPTH - 4));
  // A key arriving with no room is dropped; reports are never torn
  assign key_take = key_valid && room;
  assign step = key_shift ? key_mode_pkg::STEP_COARSE : key_mode_pkg::STEP_FINE;
  // Pair lookup done once; a function result cannot be bit-selected directly
  assign code_hit = code_lookup(first_char_reg, key_char);
  // Code sent for a key that ends locator mode
  assign exit_code = (key_kind == key_mode_pkg::KEY_ESC) ? key_mode_pkg::CODE_ESC :
                     (key_kind == key_mode_pkg::KEY_SPACE) ? key_mode_pkg::CODE_SPACE : key_char;

  // Bytes that a key event sends to the host
  always_comb begin
    push_count = 3'd0;
    for (int i = 0; i < 4; i++) begin
      push_byte[i] = 8'h00;
    end
    if (key_take && ctrl_reg[key_mode_pkg::CTRL_ONLINE] && !ctrl_reg[key_mode_pkg::CTRL_INTERP])
      begin
      unique case (mode_reg)
        key_mode_pkg::MODE_NORMAL: begin
          if (key_kind == key_mode_pkg::KEY_ESC) begin
            push_byte[0] = key_mode_pkg::CODE_ESC;
            push_count = 3'd1;
          end else if (key_kind == key_mode_pkg::KEY_CHAR) begin
            push_byte[0] = key_ctrl ? (key_char & key_mode_pkg::CODE_CTRL_MASK) : key_char;
            push_count = 3'd1;
          end else if (key_kind == key_mode_pkg::KEY_SPACE) begin
            push_byte[0] = key_mode_pkg::CODE_SPACE;
            push_count = 3'd1;
          end
        end
        key_mode_pkg::MODE_LOCATOR: begin
          if (key_kind == key_mode_pkg::KEY_ENTER || key_kind == key_mode_pkg::KEY_RETURN) begin
            push_byte[0] = key_mode_pkg::CODE_POS_X;
            push_byte[1] = cur_x_reg[9:2];
            push_byte[2] = key_mode_pkg::CODE_POS_Y;
            push_byte[3] = cur_y_reg[9:2];
            push_count = 3'd4;
          end else if (key_kind == key_mode_pkg::KEY_DELETE) begin
            push_byte[0] = key_mode_pkg::CODE_CR;
            push_count = host_entry_reg ? 3'd1 : 3'd0;
          end else if (key_kind == key_mode_pkg::KEY_CHAR || key_kind == key_mode_pkg::KEY_ESC ||
                       key_kind == key_mode_pkg::KEY_SPACE) begin
            if (host_entry_reg) begin
              push_byte[0] = key_mode_pkg::CODE_CR;
              push_byte[1] = exit_code;
              push_byte[2] = cur_x_reg[9:2];
              push_byte[3] = cur_y_reg[9:2];
              push_count = 3'd4;
            end else begin
              push_byte[0] = exit_code;
              push_byte[1] = cur_x_reg[9:2];
              push_byte[2] = cur_y_reg[9:2];
              push_count = 3'd3;
            end
          end
        end
        default: push_count = 3'd0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    // full reset leaves every mode like power-up
    if (srst || full_reset) begin
      mode_reg <= key_mode_pkg::MODE_NORMAL;
      host_entry_reg <= 1'b0;
      loc_req_d_reg <= 1'b0;
    end else begin
      loc_req_d_reg <= ctrl_reg[key_mode_pkg::CTRL_LOC_REQ];
      if (mode_reg == key_mode_pkg::MODE_NORMAL && ctrl_reg[key_mode_pkg::CTRL_LOC_REQ] &&
          !loc_req_d_reg) begin
        mode_reg <= key_mode_pkg::MODE_LOCATOR;
        host_entry_reg <= 1'b1;
      end else if (key_take) begin
        unique case (mode_reg)
          key_mode_pkg::MODE_NORMAL: begin
            if (key_kind == key_mode_pkg::KEY_SETUP) begin
              mode_reg <= key_mode_pkg::MODE_MENU;
            end else if (key_kind == key_mode_pkg::KEY_POINT && key_shift) begin
              mode_reg <= key_mode_pkg::MODE_LOCATOR;
              host_entry_reg <= 1'b0;
            end
          end
          key_mode_pkg::MODE_MENU: begin
            if (key_kind == key_mode_pkg::KEY_SETUP || key_kind == key_mode_pkg::KEY_EXIT) begin
              mode_reg <= key_mode_pkg::MODE_NORMAL;
            end
          end
          key_mode_pkg::MODE_LOCATOR: begin
            if (!(key_kind inside {key_mode_pkg::KEY_UP, key_mode_pkg::KEY_DOWN,
                                   key_mode_pkg::KEY_LEFT, key_mode_pkg::KEY_RIGHT})) begin
              mode_reg <= key_mode_pkg::MODE_NORMAL;
            end
          end
          default: mode_reg <= key_mode_pkg::MODE_NORMAL;
        endcase
      end
    end
  end

  // Menu navigation and direct entry
  always_ff @(posedge core_clk) begin
    // full reset also loses the configuration settings
    if (srst || full_reset) begin
      param_reg <= 3'd0;
      first_pend_reg <= 1'b0;
      first_char_reg <= 8'h00;
      for (int i = 0; i < key_mode_pkg::PARAM_COUNT; i++) begin
        setting_reg[i] <= 4'h0;
      end
    end else if (key_take && mode_reg == key_mode_pkg::MODE_MENU) begin
      unique case (key_kind)
        key_mode_pkg::KEY_UP, key_mode_pkg::KEY_SPACE:
          setting_reg[param_reg] <= (setting_reg[param_reg] >= pmax[param_reg]) ? 4'h0 :
                                    setting_reg[param_reg] + 4'h1;
        key_mode_pkg::KEY_DOWN:
          setting_reg[param_reg] <= (setting_reg[param_reg] == 4'h0) ? pmax[param_reg] :
                                    setting_reg[param_reg] - 4'h1;
        key_mode_pkg::KEY_RIGHT, key_mode_pkg::KEY_RETURN: param_reg <= param_reg + 3'd1;
        key_mode_pkg::KEY_LEFT: param_reg <= param_reg - 3'd1;
        key_mode_pkg::KEY_CHAR: begin
          if (key_char >= 8'h41 && key_char <= 8'h5A) begin
            if (!first_pend_reg) begin
              first_char_reg <= key_char;
              first_pend_reg <= 1'b1;
            end else begin
              first_pend_reg <= 1'b0;
              if (!code_hit[3]) begin
                param_reg <= code_hit[2:0];
              end
            end
          end else if (key_char >= key_mode_pkg::CODE_DIGIT0 &&
                       key_char - key_mode_pkg::CODE_DIGIT0 <= {4'h0, pmax[param_reg]}) begin
            setting_reg[param_reg] <= 4'(key_char - key_mode_pkg::CODE_DIGIT0);
            first_pend_reg <= 1'b0;
          end else begin
            first_pend_reg <= 1'b0;
          end
        end
        default: first_pend_reg <= 1'b0;
      endcase
    end
  end

  // Bell, reset pulse and local echo
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bell <= 1'b0;
      full_reset <= 1'b0;
      echo_valid <= 1'b0;
      echo_data <= 8'h00;
    end else begin
      bell <= 1'b0;
      full_reset <= 1'b0;
      echo_valid <= 1'b0;
      if (key_take && mode_reg == key_mode_pkg::MODE_MENU) begin
        if (key_kind == key_mode_pkg::KEY_RESET) begin
          full_reset <= key_shift;
          bell <= !key_shift;
        end else if (key_kind == key_mode_pkg::KEY_SETUP) begin
          bell <= 1'b0;
        end else if (key_kind == key_mode_pkg::KEY_CHAR) begin
          // bad code rings; bad value rings
          bell <= (first_pend_reg && key_char >= 8'h41 && key_char <= 8'h5A &&
                   code_hit[3]) ||
                  (!(key_char >= 8'h41 && key_char <= 8'h5A) &&
                   !(key_char >= key_mode_pkg::CODE_DIGIT0 &&
                     key_char - key_mode_pkg::CODE_DIGIT0 <= {4'h0, pmax[param_reg]}));
        end
      end
      if (key_take && mode_reg == key_mode_pkg::MODE_NORMAL &&
          !ctrl_reg[key_mode_pkg::CTRL_ONLINE] && key_kind == key_mode_pkg::KEY_CHAR) begin
        echo_valid <= 1'b1;
        echo_data <= key_char;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || full_reset) begin
      cur_x_reg <= 10'h000;
      cur_y_reg <= 10'h000;
    end else if (key_take && mode_reg == key_mode_pkg::MODE_LOCATOR) begin
      unique case (key_kind)
        key_mode_pkg::KEY_UP: cur_y_reg <= cur_y_reg + step;
        key_mode_pkg::KEY_DOWN: cur_y_reg <= cur_y_reg - step;
        key_mode_pkg::KEY_RIGHT: cur_x_reg <= cur_x_reg + step;
        key_mode_pkg::KEY_LEFT: cur_x_reg <= cur_x_reg - step;
        default: cur_x_reg <= cur_x_reg;
      endcase
    end
  end

  // hold toggles; only with flow control on
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_reg <= 1'b0;
    end else if (!ctrl_reg[key_mode_pkg::CTRL_FLOW]) begin
      hold_reg <= 1'b0;
    end else if (key_take && key_kind == key_mode_pkg::KEY_HOLD) begin
      hold_reg <= !hold_reg;
    end
  end

  // transmit queue; drained only while not held
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < push_count) begin
          queue[QW'(wr_ptr_reg + (QW + 1)'(i))] <= push_byte[i];
        end
      end
      wr_ptr_reg <= wr_ptr_reg + (QW + 1)'(push_count);
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end else if (!tx_valid && !hold_reg && used != '0) begin
        tx_valid <= 1'b1;
        tx_data <= queue[QW'(rd_ptr_reg)];
        rd_ptr_reg <= rd_ptr_reg + (QW + 1)'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lamp_online <= 1'b0;
      lamp_local <= 1'b0;
      lamp_hold <= 1'b0;
      lamp_interp <= 1'b0;
      lamp_copy <= 1'b0;
      host_halt <= 1'b0;
      cursor_show <= 1'b0;
    end else begin
      if (ctrl_reg[key_mode_pkg::CTRL_TEST_EN]) begin
        lamp_online <= ctrl_reg[key_mode_pkg::CTRL_TEST_LSB];
        lamp_local <= ctrl_reg[key_mode_pkg::CTRL_TEST_LSB + 1];
        lamp_interp <= ctrl_reg[key_mode_pkg::CTRL_TEST_LSB + 2];
        lamp_copy <= ctrl_reg[key_mode_pkg::CTRL_TEST_LSB + 3];
      end else begin
        lamp_online <= ctrl_reg[key_mode_pkg::CTRL_ONLINE];
        lamp_local <= !ctrl_reg[key_mode_pkg::CTRL_ONLINE];
        lamp_interp <= ctrl_reg[key_mode_pkg::CTRL_INTERP];
        lamp_copy <= copy_busy;
      end
      lamp_hold <= hold_reg;
      host_halt <= hold_reg;
      cursor_show <= (mode_reg == key_mode_pkg::MODE_LOCATOR);
    end
  end

  // Wishbone slave: one wait state, unmapped reads zero
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= key_mode_pkg::CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      // Write lands at the edge where the master samples ack
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == key_mode_pkg::REG_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            ctrl_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
      // full reset restores the power-up control word
      if (full_reset) begin
        ctrl_reg <= key_mode_pkg::CTRL_RESET;
      end
      unique case (wb_adr_i)
        key_mode_pkg::REG_CTRL: wb_dat_o <= ctrl_reg;
        key_mode_pkg::REG_STATUS: wb_dat_o <= {24'h0, 3'(used), hold_reg, host_entry_reg,
                                                first_pend_reg, mode_reg};
        key_mode_pkg::REG_PARAM: wb_dat_o <= {25'h0, setting_reg[param_reg], param_reg};
        key_mode_pkg::REG_CURSOR: wb_dat_o <= {6'h0, cur_y_reg, 6'h0, cur_x_reg};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // no reset from an unshifted press
  chk_reset_bell_only: assert property (@(posedge core_clk) disable iff (srst)
    (key_take && mode_reg == key_mode_pkg::MODE_MENU && key_kind == key_mode_pkg::KEY_RESET &&
     !key_shift) |=> bell && !full_reset) else $error("unshifted reset not bell only");
  chk_hold_flow_off: assert property (@(posedge core_clk) disable iff (srst)
    !ctrl_reg[key_mode_pkg::CTRL_FLOW] |=> !hold_reg) else $error("hold without flow");
  chk_hold_blocks_tx: assert property (@(posedge core_clk) disable iff (srst)
    (hold_reg && !tx_valid) |=> !tx_valid) else $error("transmit during hold");
  chk_online_lamp: assert property (@(posedge core_clk) disable iff (srst)
    !ctrl_reg[key_mode_pkg::CTRL_TEST_EN] |=> lamp_online == $past(ctrl_reg[0]))
    else $error("online lamp wrong");
  chk_locator_entry: assert property (@(posedge core_clk) disable iff (srst)
    (key_take && mode_reg == key_mode_pkg::MODE_NORMAL && key_kind == key_mode_pkg::KEY_POINT
     && key_shift && !(ctrl_reg[3] && !loc_req_d_reg)) |=> ##1 cursor_show)
    else $error("locator not entered");
  chk_coarse_step: assert property (@(posedge core_clk) disable iff (srst)
    (key_take && mode_reg == key_mode_pkg::MODE_LOCATOR && key_kind == key_mode_pkg::KEY_RIGHT
     && key_shift) |=> cur_x_reg == $past(cur_x_reg) + 10'd10) else $error("step not ten");
  chk_setting_wrap: assert property (@(posedge core_clk) disable iff (srst)
    (key_take && mode_reg == key_mode_pkg::MODE_MENU && key_kind == key_mode_pkg::KEY_UP &&
     setting_reg[param_reg] == pmax[param_reg]) |=> setting_reg[$past(param_reg)] == 4'h0)
    else $error("no wrap");
  chk_enter_report: assert property (@(posedge core_clk) disable iff (srst)
    (key_take && mode_reg == key_mode_pkg::MODE_LOCATOR && key_kind == key_mode_pkg::KEY_ENTER
     && ctrl_reg[0] && !ctrl_reg[2]) |=> used == $past(used) + 4 - (QW + 1)'($past(tx_valid)
     == 1'b0 && $past(used) != 0 && !$past(hold_reg))) else $error("report missing");
endmodule // key_mode_handler
`default_nettype wire

// ---- tb/host_sink.sv ----
// Host-side model that takes transmitted bytes and keeps them in order.
// Assumes tx_valid holds until a byte is taken at an edge with tx_ready.
`default_nettype none
module host_sink (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output var logic tx_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [1:0] ph = 2'h0;
  // Stall one cycle in four so the sender has to hold its byte
  always @(posedge core_clk) begin
    if (srst) begin
      ph <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      if (tx_valid && tx_ready) got.push_back(tx_data);
      tx_ready <= (ph != 2'h3);
    end
  end
endmodule // host_sink
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the key-mode handler: lamps, menu, locator, hold.
// Assumes the host_sink model and a single 100 MHz clock.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, srst = 1'b1, key_valid = 1'b0, key_shift = 1'b0, key_ctrl = 1'b0;
  logic copy_busy = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] key_kind = 4'h0, wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [7:0] key_char = 8'h00, tx_data, echo_data;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd, cur;
  logic tx_valid, tx_ready, host_halt, echo_valid, bell, full_reset, cursor_show, wb_ack_o;
  logic lamp_online, lamp_local, lamp_hold, lamp_interp, lamp_copy, bell_seen, rst_seen;
  int n_fail = 0, check_count = 0;
  key_mode_handler key_mode_handler_i (.core_clk(core_clk), .srst(srst), .key_valid(key_valid),
    .key_kind(key_kind), .key_char(key_char), .key_shift(key_shift), .key_ctrl(key_ctrl),
    .copy_busy(copy_busy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .host_halt(host_halt), .echo_valid(echo_valid), .echo_data(echo_data), .bell(bell),
    .full_reset(full_reset), .cursor_show(cursor_show), .lamp_online(lamp_online),
    .lamp_local(lamp_local), .lamp_hold(lamp_hold), .lamp_interp(lamp_interp),
    .lamp_copy(lamp_copy), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  host_sink host_sink_i (.core_clk(core_clk), .srst(srst), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  // Clock at 100 MHz
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled, bounded wait
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0000_0000, 32'h0000_0001);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // One key event, then watch the one-cycle bell and reset pulses
  task automatic press(input logic [3:0] k, input logic sh, input logic [7:0] ch);
    @(posedge core_clk);
    key_valid <= 1'b1;
    key_kind <= k;
    key_shift <= sh;
    key_char <= ch;
    @(posedge core_clk);
    key_valid <= 1'b0;
    bell_seen = 1'b0;
    rst_seen = 1'b0;
    repeat (4) begin
      @(posedge core_clk);
      bell_seen |= bell;
      rst_seen |= full_reset;
    end
  endtask
  task automatic t_lamps();
    check({lamp_online, lamp_local}, 2'b10);
    wb(1'b1, key_mode_pkg::REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    check({lamp_online, lamp_local}, 2'b01);
    wb(1'b1, key_mode_pkg::REG_CTRL, 32'h0000_0001);
    wb(1'b0, 4'h2, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask
  task automatic t_menu();
    press(key_mode_pkg::KEY_SETUP, 1'b0, 8'h00);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h51);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h51);
    check(bell_seen, 1'b1);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h54);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h53);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h33);
    wb(1'b0, key_mode_pkg::REG_PARAM, 32'h0000_0000);
    check(rd[6:0], 7'h18);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h39);
    check(bell_seen, 1'b1);
    repeat (3) press(key_mode_pkg::KEY_UP, 1'b0, 8'h00);
    press(key_mode_pkg::KEY_SPACE, 1'b0, 8'h00);
    wb(1'b0, key_mode_pkg::REG_PARAM, 32'h0000_0000);
    check(rd[6:0], 7'h38);
    press(key_mode_pkg::KEY_UP, 1'b0, 8'h00);
    wb(1'b0, key_mode_pkg::REG_PARAM, 32'h0000_0000);
    check(rd[6:0], 7'h00);
    press(key_mode_pkg::KEY_DOWN, 1'b0, 8'h00);
    wb(1'b0, key_mode_pkg::REG_PARAM, 32'h0000_0000);
    check(rd[6:0], 7'h38);
    press(key_mode_pkg::KEY_LEFT, 1'b0, 8'h00);
    wb(1'b0, key_mode_pkg::REG_PARAM, 32'h0000_0000);
    check(rd[2:0], 3'h7);
    press(key_mode_pkg::KEY_RIGHT, 1'b0, 8'h00);
    wb(1'b0, key_mode_pkg::REG_PARAM, 32'h0000_0000);
    check(rd[6:0], 7'h38);
    press(key_mode_pkg::KEY_RESET, 1'b0, 8'h00);
    check({bell_seen, rst_seen}, 2'b10);
  endtask
  task automatic t_locator();
    press(key_mode_pkg::KEY_EXIT, 1'b0, 8'h00);
    press(key_mode_pkg::KEY_POINT, 1'b1, 8'h00);
    check(cursor_show, 1'b1);
    wb(1'b0, key_mode_pkg::REG_CURSOR, 32'h0000_0000);
    cur = rd;
    press(key_mode_pkg::KEY_RIGHT, 1'b1, 8'h00);
    press(key_mode_pkg::KEY_LEFT, 1'b0, 8'h00);
    wb(1'b0, key_mode_pkg::REG_CURSOR, 32'h0000_0000);
    check(rd[9:0], cur[9:0] + 10'h009);
    cur = rd;
    press(key_mode_pkg::KEY_ENTER, 1'b0, 8'h00);
    repeat (30) @(posedge core_clk);
    check(host_sink_i.got.size(), 4);
    check({host_sink_i.got[0], host_sink_i.got[1]}, {8'hF1, cur[9:2]});
    check({host_sink_i.got[2], host_sink_i.got[3]}, {8'hF2, cur[25:18]});
    press(key_mode_pkg::KEY_POINT, 1'b1, 8'h00);
    press(key_mode_pkg::KEY_DELETE, 1'b0, 8'h00);
    repeat (30) @(posedge core_clk);
    check({cursor_show, 6'(host_sink_i.got.size())}, 7'h04);
  endtask
  task automatic t_hold();
    press(key_mode_pkg::KEY_HOLD, 1'b0, 8'h00);
    check({lamp_hold, host_halt}, 2'b00);
    press(key_mode_pkg::KEY_HOLD, 1'b0, 8'h00);
    wb(1'b1, key_mode_pkg::REG_CTRL, 32'h0000_0003);
    press(key_mode_pkg::KEY_HOLD, 1'b0, 8'h00);
    check({lamp_hold, host_halt}, 2'b11);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h41);
    check(host_sink_i.got.size(), 4);
    press(key_mode_pkg::KEY_HOLD, 1'b0, 8'h00);
    check({lamp_hold, host_halt}, 2'b00);
    copy_busy <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(lamp_copy, 1'b1);
    copy_busy <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(lamp_copy, 1'b0);
    check(host_sink_i.got.size(), 5);
    check(host_sink_i.got[4], 8'h41);
  endtask
  task automatic t_full_reset();
    press(key_mode_pkg::KEY_SETUP, 1'b0, 8'h00);
    press(key_mode_pkg::KEY_RESET, 1'b1, 8'h00);
    check(rst_seen, 1'b1);
    wb(1'b0, key_mode_pkg::REG_PARAM, 32'h0000_0000);
    check(rd[6:0], 7'h00);
    wb(1'b0, key_mode_pkg::REG_STATUS, 32'h0000_0000);
    check(rd[1:0], 2'b00);
  endtask
  // Escape, control codes, locator exits, local echo, interpreter and test lamps
  task automatic t_keys();
    press(key_mode_pkg::KEY_ESC, 1'b0, 8'h00);
    key_ctrl <= 1'b1;
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h43);
    key_ctrl <= 1'b0;
    wb(1'b1, key_mode_pkg::REG_CTRL, 32'h0000_000B);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h5A);
    press(key_mode_pkg::KEY_POINT, 1'b1, 8'h00);
    press(key_mode_pkg::KEY_SPACE, 1'b0, 8'h00);
    wb(1'b1, key_mode_pkg::REG_CTRL, 32'h0000_0002);
    press(key_mode_pkg::KEY_CHAR, 1'b0, 8'h4C);
    check(echo_data, 8'h4C);
    repeat (40) @(posedge core_clk);
    check(host_sink_i.got.size(), 14);
    check({host_sink_i.got[5], host_sink_i.got[6]}, 16'h1B03);
    check({host_sink_i.got[7], host_sink_i.got[8]}, 16'h0D5A);
    check({host_sink_i.got[9], host_sink_i.got[10]}, 16'h0000);
    check({host_sink_i.got[11], host_sink_i.got[12], host_sink_i.got[13]}, 24'h20_0000);
    wb(1'b1, key_mode_pkg::REG_CTRL, 32'h0000_0005);
    repeat (2) @(posedge core_clk);
    check(lamp_interp, 1'b1);
    wb(1'b1, key_mode_pkg::REG_CTRL, 32'h0000_0A10);
    repeat (2) @(posedge core_clk);
    check({lamp_online, lamp_local, lamp_interp, lamp_copy}, 4'b0101);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence after three reset cycles
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_lamps();
    t_menu();
    t_locator();
    t_hold();
    t_full_reset();
    t_keys();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
